/* File: src/wiper_ctl_pkg.sv */
// Purpose: constants and types for the host controller of an up/down wiper potentiometer
// Assumes: 100 MHz clock, one clock domain
// Notes: host side; the pot keeps its own counter, the host tracks a shadow copy
package wiper_ctl_pkg;
	localparam int CLK_MHZ        = 100;
	localparam int STEP_NS        = 100;
	localparam int STEP_CYC       = (STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int VPP_SETUP_MS   = 1;
	localparam int PULSE_HI_MS    = 5;
	localparam int PULSE_LO_MS    = 5;
	localparam int VPP_HOLD_MS    = 5;
	localparam int VPP_REL_MS     = 1;
	localparam int CYC_PER_MS     = CLK_MHZ * 1000;
	localparam int VPP_SETUP_CYC  = VPP_SETUP_MS * CYC_PER_MS;
	localparam int PULSE_HI_CYC   = PULSE_HI_MS * CYC_PER_MS;
	localparam int PULSE_LO_CYC   = PULSE_LO_MS * CYC_PER_MS;
	localparam int VPP_HOLD_CYC   = VPP_HOLD_MS * CYC_PER_MS;
	localparam int VPP_REL_CYC    = VPP_REL_MS * CYC_PER_MS;
	localparam int CNT_W          = 24;
	localparam int POS_W          = 5;
	localparam logic [POS_W-1:0] POS_MAX     = 5'h1f;
	localparam logic [POS_W-1:0] POS_MIN     = 5'h00;
	localparam logic [POS_W-1:0] POS_DEFAULT = 5'h10;
	localparam logic [2:0] PULSES_STORE = 3'h5;
	localparam logic [2:0] PULSES_LOCK  = 3'h6;

	typedef enum logic [1:0] {
		CMD_MOVE,
		CMD_STORE,
		CMD_LOCK
	} cmd_op_t;

	typedef struct packed {
		cmd_op_t          op;
		logic [POS_W-1:0] target;
	} cmd_t;

	typedef struct packed {
		logic select_n;
		logic dir;
		logic vpp_en;
	} pot_pins_t;
endpackage

/* File: src/wiper_timer.sv */
// Purpose: down-counter giving a one-cycle done pulse after a loaded cycle count
// Assumes: load and count share CLK
// Notes: a load while running restarts the count
`timescale 1ns/1ps
module wiper_timer (
	input  wire logic                        CLK,
	input  wire logic                        RESETN,
	input  wire logic                        LOAD,
	input  wire logic [wiper_ctl_pkg::CNT_W-1:0] COUNT,
	output logic                             DONE
);
	import wiper_ctl_pkg::*;

	logic [CNT_W-1:0] cnt_r;
	logic             run_r;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			DONE  <= 1'b0;
		end else begin
			DONE <= 1'b0;
			if (LOAD) begin
				cnt_r <= COUNT;
				run_r <= 1'b1;
			end else if (run_r) begin
				if (cnt_r <= CNT_W'(1)) begin
					run_r <= 1'b0;
					DONE  <= 1'b1;
				end else begin
					cnt_r <= cnt_r - CNT_W'(1);
				end
			end
		end
	end
endmodule

/* File: src/wiper_host.sv */
// Purpose: host controller that steps the pot wiper and runs the one-time programming sequence
// Assumes: pot powers up unprogrammed at the default tap or at a SYNC_POS given by software
// Notes: position is tracked in a shadow counter that saturates like the pot's own
`timescale 1ns/1ps
module wiper_host (
	input  wire logic                           CLK,
	input  wire logic                           RESETN,
	input  wire logic                           CMD_VALID,
	output logic                                CMD_READY,
	input  wire wiper_ctl_pkg::cmd_t            CMD,
	input  wire logic                           SYNC_VALID,
	input  wire logic [wiper_ctl_pkg::POS_W-1:0] SYNC_POS,
	output wiper_ctl_pkg::pot_pins_t            PINS,
	output logic [wiper_ctl_pkg::POS_W-1:0]     POSITION,
	output logic                                STORED,
	output logic                                LOCKED,
	output logic                                DONE
);
	import wiper_ctl_pkg::*;

	typedef enum {
		ST_IDLE,
		ST_SEL,
		ST_STEP_LO,
		ST_STEP_HI,
		ST_RELEASE,
		ST_RETURN,
		ST_VPP_UP,
		ST_PULSE_HI,
		ST_PULSE_LO,
		ST_VPP_DOWN,
		ST_END
	} state_t;

	state_t           state_r;
	cmd_t             cmd_r;
	logic [2:0]       pulses_r;
	logic             tmr_load;
	logic [CNT_W-1:0] tmr_count;
	logic             tmr_done;
	logic             go_up;
	logic             at_target;
	logic             cmd_take;
	logic [POS_W-1:0] stored_pos_r;
	logic [POS_W-1:0] take_target;
	logic             last_pulse;

	wiper_timer u_timer (
		.CLK    (CLK),
		.RESETN (RESETN),
		.LOAD   (tmr_load),
		.COUNT  (tmr_count),
		.DONE   (tmr_done)
	);

	assign CMD_READY = (state_r == ST_IDLE) && !LOCKED;
	assign cmd_take  = CMD_VALID && CMD_READY;
	assign go_up     = cmd_r.target > POSITION;
	assign at_target = cmd_r.target == POSITION;
	// a lock on a stored part first walks back to the stored tap
	assign take_target = (CMD.op == CMD_MOVE) ? CMD.target :
		(CMD.op == CMD_LOCK && STORED) ? stored_pos_r : POSITION;
	assign last_pulse = (cmd_r.op == CMD_STORE && pulses_r == PULSES_STORE - 3'h1) ||
		(pulses_r == PULSES_LOCK - 3'h1);

	// timer is loaded with the length of the state being entered
	always_comb begin
		tmr_load  = 1'b0;
		tmr_count = CNT_W'(STEP_CYC);
		case (state_r)
			ST_IDLE: begin
				tmr_load = cmd_take;
			end
			ST_SEL, ST_STEP_LO, ST_STEP_HI, ST_RELEASE: begin
				tmr_load = tmr_done;
			end
			ST_RETURN: begin
				tmr_load  = tmr_done;
				tmr_count = CNT_W'(VPP_SETUP_CYC);
			end
			ST_VPP_UP: begin
				tmr_load  = tmr_done;
				tmr_count = CNT_W'(PULSE_LO_CYC);
			end
			ST_PULSE_HI: begin
				tmr_load  = tmr_done;
				tmr_count = CNT_W'(PULSE_HI_CYC);
			end
			ST_PULSE_LO: begin
				tmr_load  = tmr_done;
				tmr_count = last_pulse ? CNT_W'(VPP_HOLD_CYC) : CNT_W'(PULSE_LO_CYC);
			end
			ST_VPP_DOWN: begin
				tmr_load  = tmr_done;
				tmr_count = CNT_W'(VPP_REL_CYC);
			end
			ST_END: begin
				tmr_load = 1'b0;
			end
			default: begin
				tmr_load = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r  <= ST_IDLE;
			cmd_r    <= '0;
			pulses_r <= '0;
			DONE     <= 1'b0;
		end else begin
			DONE <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (cmd_take) begin
						cmd_r    <= '{op: CMD.op, target: take_target};
						pulses_r <= '0;
						state_r  <= ST_SEL;
					end
				end
				ST_SEL: begin
					if (tmr_done) begin
						state_r <= at_target ? ST_RELEASE : ST_STEP_HI;
					end
				end
				ST_STEP_HI: begin
					if (tmr_done) begin
						state_r <= at_target ? ST_RELEASE : ST_STEP_LO;
					end
				end
				ST_STEP_LO: begin
					if (tmr_done) begin
						state_r <= ST_STEP_HI;
					end
				end
				ST_RELEASE: begin
					if (tmr_done && cmd_r.op == CMD_MOVE) begin
						state_r <= ST_IDLE;
						DONE    <= 1'b1;
					end else if (tmr_done) begin
						state_r <= ST_RETURN;
					end
				end
				ST_RETURN: begin
					if (tmr_done) begin
						state_r <= ST_VPP_UP;
					end
				end
				ST_VPP_UP: begin
					if (tmr_done) begin
						state_r <= ST_PULSE_HI;
					end
				end
				ST_PULSE_HI: begin
					if (tmr_done) begin
						state_r <= ST_PULSE_LO;
					end
				end
				ST_PULSE_LO: begin
					if (tmr_done) begin
						pulses_r <= pulses_r + 3'h1;
						state_r  <= last_pulse ? ST_VPP_DOWN : ST_PULSE_HI;
					end
				end
				ST_VPP_DOWN: begin
					if (tmr_done) begin
						state_r <= ST_END;
					end
				end
				ST_END: begin
					if (tmr_done) begin
						state_r <= ST_IDLE;
						DONE    <= 1'b1;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// pin drive: select falls with direction set to the move's sense
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PINS <= '{select_n: 1'b1, dir: 1'b1, vpp_en: 1'b0};
		end else begin
			case (state_r)
				ST_IDLE: begin
					PINS.select_n <= 1'b1;
					PINS.vpp_en   <= 1'b0;
					// no-move commands select in up mode so release adds no step
					if (cmd_take) begin
						PINS.dir <= take_target >= POSITION;
					end else begin
						PINS.dir <= 1'b1;
					end
				end
				ST_SEL: begin
					if (tmr_done) begin
						PINS.select_n <= 1'b0;
					end
				end
				ST_STEP_LO: begin
					if (tmr_done && !at_target) begin
						PINS.dir <= 1'b1;
					end
				end
				ST_STEP_HI: begin
					if (tmr_done && !at_target) begin
						PINS.dir <= 1'b0;
					end
				end
				ST_RELEASE: begin
					// direction is already high here, so release adds no step
					PINS.dir <= 1'b1;
					if (tmr_done) begin
						PINS.select_n <= 1'b1;
					end
				end
				ST_RETURN: begin
					PINS.dir <= 1'b1;
					if (tmr_done) begin
						PINS.vpp_en <= 1'b1;
					end
				end
				ST_VPP_UP: begin
					if (tmr_done) begin
						PINS.select_n <= 1'b0;
					end
				end
				ST_PULSE_HI: begin
					if (tmr_done) begin
						PINS.select_n <= 1'b1;
					end
				end
				ST_PULSE_LO: begin
					if (tmr_done) begin
						PINS.select_n <= 1'b0;
					end
				end
				ST_VPP_DOWN: begin
					if (tmr_done) begin
						PINS.vpp_en <= 1'b0;
					end
				end
				ST_END: begin
					if (tmr_done) begin
						PINS.select_n <= 1'b1;
					end
				end
				default: begin
					PINS.select_n <= 1'b1;
				end
			endcase
		end
	end

	// shadow wiper counter, one step per direction rising edge
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			POSITION <= POS_DEFAULT;
		end else if (state_r == ST_IDLE && SYNC_VALID) begin
			POSITION <= SYNC_POS;
		end else if (state_r == ST_STEP_LO && tmr_done && !at_target) begin
			if (go_up && POSITION != POS_MAX) begin
				POSITION <= POSITION + 5'h01;
			end else if (!go_up && POSITION != POS_MIN) begin
				POSITION <= POSITION - 5'h01;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			STORED       <= 1'b0;
			LOCKED       <= 1'b0;
			stored_pos_r <= POS_DEFAULT;
		end else if (state_r == ST_VPP_DOWN && tmr_done) begin
			if (!STORED) begin
				STORED       <= 1'b1;
				stored_pos_r <= POSITION;
			end
			if (cmd_r.op == CMD_LOCK) begin
				LOCKED <= 1'b1;
			end
		end
	end

endmodule

/* File: test/wiper_host_chk.sv */
// Purpose: pin order checks on the wiper host
// Assumes: one clock domain
// Notes: bound to wiper_host below
`timescale 1ns/1ps
module wiper_host_chk (
	input wire logic                             CLK,
	input wire logic                             RESETN,
	input wire logic                             CMD_READY,
	input wire logic                             SYNC_VALID,
	input wire wiper_ctl_pkg::pot_pins_t         PINS,
	input wire logic [wiper_ctl_pkg::POS_W-1:0]  POSITION,
	input wire logic                             LOCKED,
	input wire logic                             DONE
);
	import wiper_ctl_pkg::*;
	logic [CNT_W-1:0] vpp_age_r;
	// cycles the supply has been on, saturating
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			vpp_age_r <= '0;
		end else if (!PINS.vpp_en) begin
			vpp_age_r <= '0;
		end else if (vpp_age_r != '1) begin
			vpp_age_r <= vpp_age_r + CNT_W'(1);
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_vpp_after_dir: assert property ($rose(PINS.vpp_en) |-> PINS.dir && PINS.select_n)
		else $error("supply raised before dir high");
	a_vpp_before_sel: assert property ($fell(PINS.select_n) && PINS.vpp_en
		|-> vpp_age_r >= CNT_W'(VPP_SETUP_CYC))
		else $error("select dropped with supply just raised");
	a_pulse_no_step: assert property ($rose(PINS.select_n) && PINS.vpp_en |-> PINS.dir)
		else $error("programming pulse with dir low");
	a_done_released: assert property (DONE |-> !PINS.vpp_en && PINS.select_n)
		else $error("command ended with pins active");
	a_lock_refuses: assert property (LOCKED |-> !CMD_READY)
		else $error("locked host ready");
	a_idle_pos_held: assert property ($changed(POSITION) |-> !$past(PINS.select_n) || $past(SYNC_VALID))
		else $error("position moved while idle");
	a_single_step: assert property ($changed(POSITION) && !$past(SYNC_VALID)
		|-> POSITION == $past(POSITION) + 5'h01 || POSITION == $past(POSITION) - 5'h01)
		else $error("position moved more than one tap");
endmodule
bind wiper_host wiper_host_chk i_chk (.CLK(CLK), .RESETN(RESETN), .CMD_READY(CMD_READY),
	.SYNC_VALID(SYNC_VALID), .PINS(PINS), .POSITION(POSITION), .LOCKED(LOCKED), .DONE(DONE));

/* File: test/wiper_pot.sv */
// Purpose: clocked model of the up/down pot
// Assumes: pins sampled on CLK
// Notes: RESETN stands for power-up
`timescale 1ns/1ps
module wiper_pot (
	input  wire logic                             CLK,
	input  wire logic                             RESETN,
	input  wire wiper_ctl_pkg::pot_pins_t         PINS,
	output logic [wiper_ctl_pkg::POS_W-1:0]       WIPER
);
	import wiper_ctl_pkg::*;
	pot_pins_t  prev_r;
	logic       up_r;
	logic       lock_r;
	logic [2:0] pulses_r;
	logic       step;
	logic       sel_rise;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) prev_r <= 3'h6;
		else prev_r <= PINS;
	end
	assign sel_rise = PINS.select_n && !prev_r.select_n;
	assign step = !lock_r && !PINS.vpp_en && ((!PINS.select_n && !prev_r.select_n && PINS.dir
		&& !prev_r.dir) || (sel_rise && !PINS.dir));
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) up_r <= 1'b1;
		else if (!PINS.select_n && prev_r.select_n) up_r <= PINS.dir;
	end
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) WIPER <= POS_DEFAULT;
		else if (step && up_r && WIPER != POS_MAX) WIPER <= WIPER + 5'h01;
		else if (step && !up_r && WIPER != POS_MIN) WIPER <= WIPER - 5'h01;
	end
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			pulses_r <= 3'h0;
			lock_r <= 1'b0;
		end else if (PINS.vpp_en && sel_rise && !lock_r) begin
			pulses_r <= pulses_r + 3'h1;
			lock_r <= (pulses_r == 3'h5);
		end
	end
endmodule

/* File: test/testbench.sv */
// Purpose: self-checking bench for the wiper host
// Assumes: pot model on the pins
// Notes: programming is only started, its ms timing is too long to run
`timescale 1ns/1ps
module testbench;
	import wiper_ctl_pkg::*;
	logic             clk, resetn, cmd_valid, cmd_ready, sync_valid, stored, locked, done;
	cmd_t             cmd;
	pot_pins_t        pins;
	logic [POS_W-1:0] sync_pos, position, wiper;
	logic [POS_W-1:0] exp_q[$];
	logic [31:0]      rnd;
	int               err_count, total_checks, cycles;
	wiper_host i_dut (.CLK(clk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
		.CMD(cmd), .SYNC_VALID(sync_valid), .SYNC_POS(sync_pos), .PINS(pins),
		.POSITION(position), .STORED(stored), .LOCKED(locked), .DONE(done));
	wiper_pot i_pot (.CLK(clk), .RESETN(resetn), .PINS(pins), .WIPER(wiper));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction
	task automatic idle();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (cmd_ready !== 1'b1) chk(1'b0, "ready timeout");
	endtask
	task automatic issue(input cmd_op_t op, input logic [POS_W-1:0] t);
		idle();
		cmd_valid = 1'b1;
		cmd = '{op, t};
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
	endtask
	task automatic move(input logic [POS_W-1:0] t);
		exp_q.push_back(t);
		issue(CMD_MOVE, t);
	endtask
	task automatic sync(input logic [POS_W-1:0] p);
		idle();
		sync_valid = 1'b1;
		sync_pos = p;
		@(posedge clk);
		#1;
		sync_valid = 1'b0;
		chk(position === p, "sync not loaded");
	endtask
	always @(posedge clk) begin
		cycles++;
		if (done === 1'b1 && exp_q.size() == 0) chk(1'b0, "unexpected done");
		if (done === 1'b1 && exp_q.size() != 0) begin
			chk(position === exp_q[0] && wiper === exp_q[0], "wiper mismatch");
			void'(exp_q.pop_front());
		end
		if (cycles == 60000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		rnd = 32'h0000963d;
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		sync_valid = 1'b0;
		sync_pos = '0;
		repeat (3) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk(position === POS_DEFAULT && wiper === POS_DEFAULT, "power-up tap");
		for (int i = 0; i < 6; i++) begin
			rnd = xorshift(rnd);
			move(rnd[4:0]);
		end
		// shadow put out of step so the pot runs into its end stops
		move(POS_MIN);
		sync(POS_MAX);
		move(POS_MIN);
		move(POS_MAX);
		sync(POS_MIN);
		move(POS_MAX);
		issue(CMD_STORE, 5'h00);
		chk(cmd_ready === 1'b0, "store not busy");
		repeat (40) @(posedge clk);
		#1;
		chk(pins.vpp_en === 1'b1 && pins.dir === 1'b1 && pins.select_n === 1'b1, "prog setup");
		resetn = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk(pins.vpp_en === 1'b0 && position === POS_DEFAULT, "reset in store");
		move(5'h11);
		idle();
		@(posedge clk);
		#1;
		chk(exp_q.size() == 0, "move never finished");
		give_verdict();
	end
endmodule
